// file: ustbp_port.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Sixteen 32-bit aliased words each reach receive buffer and transmit holding.
// - Read returns byte from serial input, or infrared input in infrared mode.
// - FIFOs off: new character overwrites unread byte and flags overrun.
// - FIFOs on: a read returns and removes the receive FIFO head.
// - Receive FIFO full: keep contents, drop new character, flag overrun.
// - Written byte goes to serial output, or infrared output in infrared mode.
// - FIFOs off and holding empty: one write clears the holding-empty flag.
// - FIFOs off: further writes before empty again overwrite pending byte.
// - FIFOs on: accept writes up to transmit depth, default 16.
// - Writes while transmit FIFO is full are discarded.
module ustbp_port
  import ustbp_pkg::*;
#(
  parameter int DEPTH = USTBP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  // Mode from the rest of the UART
  input  wire logic        fifo_enable,
  input  wire logic        ir_mode,
  // Receive shifters
  input  wire logic        uart_rx_valid,
  input  wire logic [7:0]  uart_rx_byte,
  input  wire logic        ir_rx_valid,
  input  wire logic [7:0]  ir_rx_byte,
  // Transmit shifters
  output logic             tx_uart_valid,
  output logic             tx_ir_valid,
  output logic [7:0]       tx_byte,
  input  wire logic        tx_take,
  // Status towards the line state logic
  output logic             rx_data_ready_flag,
  output logic             tx_holding_empty_flag,
  output var  logic        rx_overrun_pulse,
  // Interrupt
  output logic             irq
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_CNT  = CW'(1);
  localparam logic [CW-1:0] ZERO_CNT = CW'(0);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic is_alias(input logic [31:0] a);
    is_alias = (a >= USTBP_ALIAS_BASE) && (a <= USTBP_ALIAS_LAST)
               && (a[1:0] == 2'b00);
  endfunction

  wire logic alias_rd = reg_rd && is_alias(reg_addr);
  wire logic alias_wr = reg_wr && is_alias(reg_addr);
  wire logic ls_rd    = reg_rd && (reg_addr == USTBP_LINE_STATE);
  wire logic st_rd    = reg_rd && (reg_addr == USTBP_IRQ_STATUS);
  wire logic en_rd    = reg_rd && (reg_addr == USTBP_IRQ_ENABLE);
  wire logic clr_wr   = reg_wr && (reg_addr == USTBP_IRQ_CLEAR);
  wire logic en_wr    = reg_wr && (reg_addr == USTBP_IRQ_ENABLE);

  // ---------------------------------------------------------------
  // Mode tracking
  // ---------------------------------------------------------------
  // Both queues are emptied when the FIFO mode changes, so a
  // one-deep holding register never inherits a deeper backlog.
  logic fifo_en;
  wire logic flush = fifo_enable ^ fifo_en;
  wire logic [CW-1:0] cap = fifo_en ? FULL_CNT : ONE_CNT;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fifo_en <= 1'b0;
    end else begin
      fifo_en <= fifo_enable;
    end
  end

  // ---------------------------------------------------------------
  // Receive side
  // ---------------------------------------------------------------
  logic [7:0]    rx_mem [DEPTH];
  logic [AW-1:0] rx_rd_ptr;
  logic [AW-1:0] rx_wr_ptr;
  logic [CW-1:0] rx_count;

  wire logic       rx_in_valid = ir_mode ? ir_rx_valid : uart_rx_valid;
  wire logic [7:0] rx_in_byte  = ir_mode ? ir_rx_byte : uart_rx_byte;
  wire logic       rx_nonempty = (rx_count != ZERO_CNT);
  wire logic [7:0] rx_head     = rx_mem[rx_rd_ptr];
  wire logic       rx_pop      = alias_rd && rx_nonempty && !flush;
  wire logic       rx_full     = (rx_count == cap);
  wire logic       rx_push     = rx_in_valid && !flush
                                 && (!rx_full || rx_pop);
  wire logic       rx_overwr   = rx_in_valid && !flush && !fifo_en
                                 && rx_full && !rx_pop;
  wire logic       rx_drop     = rx_in_valid && !flush && fifo_en
                                 && rx_full && !rx_pop;
  wire logic       rx_overrun  = rx_overwr || rx_drop;

  wire logic [CW-1:0] next_rx_count = flush ? ZERO_CNT
    : rx_count + CW'(rx_push) - CW'(rx_pop);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        rx_mem[i] <= USTBP_BYTE_RST;
      end
    end else if (rx_push) begin
      rx_mem[rx_wr_ptr] <= rx_in_byte;
    end else if (rx_overwr) begin
      rx_mem[rx_rd_ptr] <= rx_in_byte;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_rd_ptr <= '0;
      rx_wr_ptr <= '0;
      rx_count  <= ZERO_CNT;
    end else begin
      rx_rd_ptr <= flush ? rx_wr_ptr : rx_rd_ptr + AW'(rx_pop);
      rx_wr_ptr <= rx_wr_ptr + AW'(rx_push);
      rx_count  <= next_rx_count;
    end
  end

  assign rx_data_ready_flag = rx_nonempty;

  // ---------------------------------------------------------------
  // Transmit side
  // ---------------------------------------------------------------
  logic [7:0]    tx_mem [DEPTH];
  logic [AW-1:0] tx_rd_ptr;
  logic [AW-1:0] tx_wr_ptr;
  logic [CW-1:0] tx_count;

  wire logic       tx_nonempty = (tx_count != ZERO_CNT);
  wire logic       tx_pop      = tx_take && tx_nonempty && !flush;
  wire logic       tx_full     = (tx_count == cap);
  wire logic [7:0] tx_wbyte    = reg_wdata[7:0];
  wire logic       tx_push     = alias_wr && !flush
                                 && (!tx_full || tx_pop);
  wire logic       tx_overwr   = alias_wr && !flush && !fifo_en
                                 && tx_full && !tx_pop;
  // A full FIFO simply ignores the write: no push, no overwrite

  wire logic [CW-1:0] next_tx_count = flush ? ZERO_CNT
    : tx_count + CW'(tx_push) - CW'(tx_pop);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        tx_mem[i] <= USTBP_BYTE_RST;
      end
    end else if (tx_push) begin
      tx_mem[tx_wr_ptr] <= tx_wbyte;
    end else if (tx_overwr) begin
      tx_mem[tx_rd_ptr] <= tx_wbyte;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_rd_ptr <= '0;
      tx_wr_ptr <= '0;
      tx_count  <= ZERO_CNT;
    end else begin
      tx_rd_ptr <= flush ? tx_wr_ptr : tx_rd_ptr + AW'(tx_pop);
      tx_wr_ptr <= tx_wr_ptr + AW'(tx_push);
      tx_count  <= next_tx_count;
    end
  end

  assign tx_byte               = tx_mem[tx_rd_ptr];
  assign tx_uart_valid         = tx_nonempty && !ir_mode;
  assign tx_ir_valid           = tx_nonempty && ir_mode;
  assign tx_holding_empty_flag = !tx_nonempty;

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  logic [USTBP_IRQ_W-1:0] irq_status;
  logic [USTBP_IRQ_W-1:0] irq_enable;

  wire logic tx_drained = tx_pop && (tx_count == ONE_CNT) && !tx_push;
  wire logic [USTBP_IRQ_W-1:0] irq_events =
    {tx_drained, rx_push, rx_overrun};
  wire logic [USTBP_IRQ_W-1:0] irq_clear =
    clr_wr ? reg_wdata[USTBP_IRQ_W-1:0] : '0;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status       <= USTBP_IRQ_RST;
      irq_enable       <= USTBP_IRQ_RST;
      rx_overrun_pulse <= 1'b0;
    end else begin
      irq_status       <= (irq_status & ~irq_clear) | irq_events;
      rx_overrun_pulse <= rx_overrun;
      if (en_wr) begin
        irq_enable <= reg_wdata[USTBP_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  wire logic [31:0] ls_word =
      (32'(rx_nonempty) << USTBP_LS_DR_BIT)
    | (32'(irq_status[USTBP_IRQ_OVERRUN]) << USTBP_LS_OE_BIT)
    | (32'(!tx_nonempty) << USTBP_LS_TX_HOLDING_EMPTY_FLAG_BIT);

  wire logic [31:0] next_rdata =
      alias_rd ? {24'h000000, rx_head}
    : ls_rd    ? ls_word
    : st_rd    ? 32'(irq_status)
    : en_rd    ? 32'(irq_enable)
    : USTBP_RDATA_RST;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= USTBP_RDATA_RST;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_alias_read;
    @(posedge sys_clk) disable iff (!reset_n)
    alias_rd |=> reg_rdata == {24'h000000, $past(rx_head)};
  endproperty
  a_alias_read: assert property (p_alias_read)
    else $error("alias read returned wrong byte");

  property p_ir_source;
    @(posedge sys_clk) disable iff (!reset_n)
    (ir_mode && ir_rx_valid && rx_count == ZERO_CNT && !flush)
      |=> rx_data_ready_flag && rx_head == $past(ir_rx_byte);
  endproperty
  a_ir_source: assert property (p_ir_source)
    else $error("infrared byte not captured in infrared mode");

  property p_overwrite_rx;
    @(posedge sys_clk) disable iff (!reset_n)
    (!fifo_en && !flush && rx_in_valid && rx_nonempty && !alias_rd)
      |=> rx_count == ONE_CNT && rx_head == $past(rx_in_byte)
          && irq_status[USTBP_IRQ_OVERRUN] && rx_overrun_pulse;
  endproperty
  a_overwrite_rx: assert property (p_overwrite_rx)
    else $error("unread byte not overwritten with overrun");

  property p_fifo_pop;
    @(posedge sys_clk) disable iff (!reset_n)
    (fifo_en && !flush && alias_rd && rx_count > ONE_CNT && !rx_in_valid)
      |=> rx_count == $past(rx_count) - ONE_CNT && rx_data_ready_flag;
  endproperty
  a_fifo_pop: assert property (p_fifo_pop)
    else $error("head read did not remove one entry");

  property p_rx_full_drop;
    @(posedge sys_clk) disable iff (!reset_n)
    (fifo_en && !flush && rx_count == FULL_CNT && rx_in_valid && !alias_rd)
      |=> rx_count == FULL_CNT && $stable(rx_head) && rx_overrun_pulse;
  endproperty
  a_rx_full_drop: assert property (p_rx_full_drop)
    else $error("full receive FIFO did not drop and flag overrun");

  property p_tx_route;
    @(posedge sys_clk) disable iff (!reset_n)
    tx_nonempty |-> (tx_ir_valid == ir_mode) && (tx_uart_valid != ir_mode);
  endproperty
  a_tx_route: assert property (p_tx_route)
    else $error("transmit byte routed to wrong output");

  property p_tx_holding_empty_flag_clear;
    @(posedge sys_clk) disable iff (!reset_n)
    (!fifo_en && !flush && alias_wr && tx_holding_empty_flag)
      |=> !tx_holding_empty_flag && tx_byte == $past(reg_wdata[7:0]);
  endproperty
  a_tx_holding_empty_flag_clear: assert property (p_tx_holding_empty_flag_clear)
    else $error("write did not clear holding-empty flag");

  property p_tx_overwrite;
    @(posedge sys_clk) disable iff (!reset_n)
    (!fifo_en && !flush && alias_wr && tx_nonempty && !tx_take)
      |=> tx_count == ONE_CNT && tx_byte == $past(reg_wdata[7:0]);
  endproperty
  a_tx_overwrite: assert property (p_tx_overwrite)
    else $error("pending transmit byte not overwritten");

  property p_tx_accept;
    @(posedge sys_clk) disable iff (!reset_n)
    (fifo_en && !flush && alias_wr && tx_count < FULL_CNT && !tx_take)
      |=> tx_count == $past(tx_count) + ONE_CNT;
  endproperty
  a_tx_accept: assert property (p_tx_accept)
    else $error("transmit FIFO refused write below depth");

  property p_tx_full_drop;
    @(posedge sys_clk) disable iff (!reset_n)
    (fifo_en && !flush && alias_wr && tx_count == FULL_CNT && !tx_take)
      |=> tx_count == FULL_CNT && $stable(tx_byte);
  endproperty
  a_tx_full_drop: assert property (p_tx_full_drop)
    else $error("write to full transmit FIFO was not discarded");

endmodule

`default_nettype wire

// file: ustbp_pkg.sv
package ustbp_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  // Sixteen aliased words of receive buffer / transmit holding
  localparam logic [31:0] USTBP_ALIAS_BASE   = 32'h50001130;
  localparam int          USTBP_ALIAS_COUNT  = 16;
  localparam logic [31:0] USTBP_ALIAS_LAST   = 32'h5000116C;
  localparam logic [31:0] USTBP_SHADOW_DATA1 = 32'h50001134;
  localparam logic [31:0] USTBP_SHADOW_DATA2 = 32'h50001138;
  localparam logic [31:0] USTBP_LINE_STATE   = 32'h50001180;
  localparam logic [31:0] USTBP_IRQ_STATUS   = 32'h50001184;
  localparam logic [31:0] USTBP_IRQ_CLEAR    = 32'h50001188;
  localparam logic [31:0] USTBP_IRQ_ENABLE   = 32'h5000118C;

  // ---------------------------------------------------------------
  // Field layouts
  // ---------------------------------------------------------------
  localparam int USTBP_DATA_W      = 8;
  localparam int USTBP_LS_DR_BIT   = 0;
  localparam int USTBP_LS_OE_BIT   = 1;
  localparam int USTBP_LS_TX_HOLDING_EMPTY_FLAG_BIT = 5;
  localparam int USTBP_IRQ_W       = 3;
  localparam int USTBP_IRQ_OVERRUN = 0;
  localparam int USTBP_IRQ_RX      = 1;
  localparam int USTBP_IRQ_TXEMPTY = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] USTBP_RDATA_RST  = 32'h00000000;
  localparam logic [2:0]  USTBP_IRQ_RST    = 3'h0;
  localparam logic [7:0]  USTBP_BYTE_RST   = 8'h00;
  localparam int          USTBP_FIFO_DEPTH = 16;

endpackage

// file: ustbp_peer.sv
`timescale 1ns/10ps
`default_nettype none

module ustbp_peer (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Mode and pacing
  input  wire logic       ir_mode,
  input  wire logic       stall,
  // Characters toward the port
  output logic            uart_rx_valid,
  output logic [7:0]      uart_rx_byte,
  output logic            ir_rx_valid,
  output logic [7:0]      ir_rx_byte,
  // Characters from the port
  input  wire logic       tx_uart_valid,
  input  wire logic       tx_ir_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_take
);
  logic [7:0] got[$];
  logic       want;

  // Only the shifter of the active mode takes a byte
  assign want = ir_mode ? tx_ir_valid : tx_uart_valid;

  initial begin
    uart_rx_valid = 1'h0;
    ir_rx_valid   = 1'h0;
    uart_rx_byte  = 8'h00;
    ir_rx_byte    = 8'h00;
  end

  // Idle data lines carry the inverse, so a stale byte never looks valid
  task automatic send(input logic [7:0] b);
    @(posedge sys_clk);
    uart_rx_valid <= !ir_mode;
    ir_rx_valid   <= ir_mode;
    uart_rx_byte  <= b;
    ir_rx_byte    <= b;
    @(posedge sys_clk);
    uart_rx_valid <= 1'h0;
    ir_rx_valid   <= 1'h0;
    uart_rx_byte  <= ~b;
    ir_rx_byte    <= ~b;
  endtask

  // One byte per frame: never two takes in a row
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_take <= 1'h0;
    end else begin
      if (tx_take) begin
        got.push_back(tx_byte);
      end
      tx_take <= want && !stall && !tx_take;
    end
  end
endmodule

`default_nettype wire

// file: ustbp_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
  end \
end

module tb
  import ustbp_pkg::*;
;
  typedef struct {
    logic       ir;
    logic       fe;
    logic [3:0] k;
    logic [7:0] b;
  } ustbp_row_t;
  localparam int DEPTH = 4;
  logic        sys_clk, reset_n, reg_wr, reg_rd, fifo_enable, ir_mode;
  logic        stall, uv, iv, tuv, tiv, take, rdy, empty, ovr, irq;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [7:0]  ub, ib, tb_byte;
  int          cmp_count, fail_count, ovr_n;
  ustbp_row_t  rows[6];

  ustbp_port #(.DEPTH(DEPTH)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fifo_enable(fifo_enable),
    .ir_mode(ir_mode), .uart_rx_valid(uv), .uart_rx_byte(ub),
    .ir_rx_valid(iv), .ir_rx_byte(ib), .tx_uart_valid(tuv),
    .tx_ir_valid(tiv), .tx_byte(tb_byte), .tx_take(take),
    .rx_data_ready_flag(rdy), .tx_holding_empty_flag(empty),
    .rx_overrun_pulse(ovr), .irq(irq));
  ustbp_peer peer (.sys_clk(sys_clk), .reset_n(reset_n), .ir_mode(ir_mode),
    .stall(stall), .uart_rx_valid(uv), .uart_rx_byte(ub), .ir_rx_valid(iv),
    .ir_rx_byte(ib), .tx_uart_valid(tuv), .tx_ir_valid(tiv),
    .tx_byte(tb_byte), .tx_take(take));

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (ovr === 1'h1) begin
      ovr_n++;
    end
  end

  task automatic tick();
    @(posedge sys_clk);
  endtask

  function automatic logic [31:0] al(input logic [3:0] k);
    return USTBP_ALIAS_BASE + {26'h0, k, 2'h0};
  endfunction

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'h1;
    tick();
    reg_wr    <= 1'h0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    tick();
    reg_rd   <= 1'h0;
    tick();
    v = reg_rdata;
  endtask

  task automatic wait_taken(input int n);
    int i;
    i = 0;
    while (peer.got.size() < n && i < 200) begin
      tick();
      i++;
    end
    if (peer.got.size() < n) begin
      fail_count++;
      $display("[ERR] tx_take expected %0d seen %0d", n, peer.got.size());
      finish_test();
    end
  endtask

  // FIFO mode changes flush both queues, so settle before traffic
  task automatic set_mode(input logic ir, input logic fe);
    ir_mode     <= ir;
    fifo_enable <= fe;
    repeat (3) tick();
    peer.got.delete();
  endtask

  initial begin
    rows = '{'{1'h0, 1'h0, 4'h0, 8'h5A}, '{1'h1, 1'h0, 4'h1, 8'hA5},
             '{1'h0, 1'h1, 4'hF, 8'h3C}, '{1'h1, 1'h1, 4'h7, 8'hC3},
             '{1'h0, 1'h0, 4'h8, 8'h00}, '{1'h1, 1'h1, 4'h2, 8'hFF}};
    {reset_n, reg_wr, reg_rd, fifo_enable, ir_mode, stall} = 6'h00;
    reg_addr  = 32'h00000000;
    reg_wdata = 32'h00000000;
    repeat (8) tick();
    reset_n <= 1'h1;
    repeat (2) tick();
    `CHK("holding_empty", 1'h1, empty)
    rd(USTBP_LINE_STATE, d);
    `CHK("line_state", 32'h00000020, d)
    rd(32'h50001190, d);
    `CHK("unmapped", 32'h00000000, d)
    wr(USTBP_IRQ_ENABLE, 32'h00000001);
    rd(USTBP_IRQ_ENABLE, d);
    `CHK("irq_enable", 32'h00000001, d)
    foreach (rows[i]) begin
      set_mode(rows[i].ir, rows[i].fe);
      peer.send(rows[i].b);
      tick();
      `CHK("rx_ready", 1'h1, rdy)
      rd(al(rows[i].k), d);
      `CHK("rx_byte", {24'h0, rows[i].b}, d)
      `CHK("rx_ready_low", 1'h0, rdy)
      `CHK("tx_empty", 1'h1, empty)
      wr(al(rows[i].k), {24'h0, ~rows[i].b});
      wait_taken(1);
      `CHK("tx_byte", ~rows[i].b, peer.got[0])
    end
    set_mode(1'h0, 1'h0);
    ovr_n = 0;
    peer.send(8'h31);
    peer.send(8'h32);
    tick();
    rd(al(4'h3), d);
    `CHK("rx_overwrite", 32'h00000032, d)
    `CHK("overrun_pulse", 1, ovr_n)
    `CHK("irq_on", 1'h1, irq)
    rd(USTBP_LINE_STATE, d);
    `CHK("line_state_oe", 32'h00000022, d)
    wr(USTBP_IRQ_CLEAR, 32'h00000001);
    tick();
    `CHK("irq_off", 1'h0, irq)
    rd(USTBP_IRQ_STATUS, d);
    `CHK("irq_status", 32'h00000006, d)
    set_mode(1'h0, 1'h1);
    for (int i = 0; i <= DEPTH; i++) peer.send(8'hC0 + 8'(i));
    // Let the pulse counter see the last overrun before looking
    repeat (2) tick();
    `CHK("overrun_full", 2, ovr_n)
    for (int i = 0; i < DEPTH; i++) begin
      rd(al(4'(i)), d);
      `CHK("rx_fifo", {24'h0, 8'hC0 + 8'(i)}, d)
    end
    `CHK("rx_drained", 1'h0, rdy)
    set_mode(1'h0, 1'h0);
    stall <= 1'h1;
    wr(al(4'h5), 32'h00000011);
    tick();
    `CHK("holding_busy", 1'h0, empty)
    wr(al(4'h9), 32'h00000022);
    stall <= 1'h0;
    wait_taken(1);
    repeat (6) tick();
    `CHK("tx_overwrite", 8'h22, peer.got[0])
    `CHK("tx_count", 1, peer.got.size())
    set_mode(1'h1, 1'h1);
    stall <= 1'h1;
    for (int i = 0; i <= DEPTH; i++) begin
      wr(al(4'(i)), 32'h000000A0 + i);
      tick();
    end
    stall <= 1'h0;
    wait_taken(DEPTH);
    repeat (8) tick();
    `CHK("tx_fifo_count", DEPTH, peer.got.size())
    `CHK("tx_fifo_head", 8'hA0, peer.got[0])
    `CHK("tx_fifo_tail", 8'hA0 + 8'(DEPTH - 1), peer.got[DEPTH - 1])
    // Reset in mid-run with a byte waiting
    peer.send(8'h44);
    reset_n <= 1'h0;
    repeat (2) tick();
    `CHK("reset_ready", 1'h0, rdy)
    `CHK("reset_empty", 1'h1, empty)
    `CHK("reset_irq", 1'h0, irq)
    reset_n <= 1'h1;
    repeat (2) tick();
    rd(USTBP_IRQ_ENABLE, d);
    `CHK("reset_enable", 32'h00000000, d)
    rd(USTBP_IRQ_STATUS, d);
    `CHK("reset_status", 32'h00000000, d)
    finish_test();
  end
endmodule

`default_nettype wire
